// [rsr_defines.svh]
// register map, field positions and sizes of the rate and status readback bank
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// ****************************************************************
// register addresses on the control port
// ****************************************************************
`define RSR_ADDR_W 8
`define RSR_RATIO_LSB 8'h42
`define RSR_RATIO_MSB 8'h45
`define RSR_CS_LSB 8'h46
`define RSR_CS_MSB 8'h5D

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define RSR_RATIO_W 32
`define RSR_CS_BITS 8'hC0
`define RSR_CS_BYTES 24
`define RSR_CS_IDX_W 5
`define RSR_RATIO_RST 32'h0000_0000
`define RSR_BYTE_RST 8'h00
`define RSR_UNMAPPED 8'h00

`endif

// [rsr_pkg.sv]
// shared types of the rate and status readback bank
package rsr_pkg;
    typedef logic [7:0] rsr_byte_t;
    typedef logic [7:0] rsr_addr_t;
    typedef logic [31:0] rsr_ratio_t;
    // source of the byte travelling down the read pipeline
    typedef enum logic [1:0] {
        RSR_SEL_NONE = 2'b00,
        RSR_SEL_RATIO = 2'b01,
        RSR_SEL_CS = 2'b10
    } rsr_sel_t;
endpackage

// [rsr_cs_mem.sv]
// byte memory holding the received channel-status block
`timescale 1ns/100ps
`include "rsr_defines.svh"
module rsr_cs_mem #(
    parameter int DEPTH = `RSR_CS_BYTES,
    parameter int IDX_W = `RSR_CS_IDX_W
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // write side
    input wire logic wr_en_in,
    input wire logic [IDX_W-1:0] wr_idx_in,
    input wire rsr_pkg::rsr_byte_t wr_data_in,
    // read side
    input wire logic [IDX_W-1:0] rd_idx_in,
    output rsr_pkg::rsr_byte_t rd_data_out
);
    import rsr_pkg::*;

    rsr_byte_t mem_r [DEPTH];
    rsr_byte_t rd_data_r;
    rsr_byte_t rd_data_nxt;

    // read data selection, out-of-range index reads zero
    always_comb begin
        rd_data_nxt = `RSR_BYTE_RST;
        if (int'(rd_idx_in) < DEPTH) begin
            rd_data_nxt = mem_r[rd_idx_in];
        end
    end

    // storage and registered read port, cleared at reset
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= `RSR_BYTE_RST;
            end
            rd_data_r <= `RSR_BYTE_RST;
        end else if (ce_in) begin
            if (wr_en_in && (int'(wr_idx_in) < DEPTH)) begin
                mem_r[wr_idx_in] <= wr_data_in;
            end
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_out = rd_data_r;
endmodule

// [rsr_readback.sv]
// rate ratio snapshot and channel-status readback bank on the control port
// Behaviour
// R1: ratio is read-only, host cannot alter it
// R2: ratio bytes at registers 66 to 69
// R3: ratio scales master clock to raw_sample_rate
// R4: reading byte 66 latches whole ratio
// R5: host reads ratio bytes lowest first
// R6: 192-bit status at registers 70 to 93
// R7: received status bits readable by host
// R8: status bits stored raw, not interpreted
// R9: first received bit lands in bit 0, register 70
`timescale 1ns/100ps
`include "rsr_defines.svh"
module rsr_readback #(
    parameter int RATIO_W = `RSR_RATIO_W,
    parameter int CS_BYTES = `RSR_CS_BYTES
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // ratio from the rate tracker, master clock domain
    input wire rsr_pkg::rsr_ratio_t rate_ratio_in,
    // serial channel-status bits from the receiver, master clock domain
    input wire logic cs_bit_in,
    input wire logic cs_bit_valid_in,
    input wire logic cs_block_start_in,
    // control port read access
    input wire logic rd_en_in,
    input wire rsr_pkg::rsr_addr_t rd_addr_in,
    output rsr_pkg::rsr_byte_t rd_data_out,
    output logic rd_valid_out
);
    import rsr_pkg::*;

    // ****************************************************************
    // operating notes
    // ****************************************************************
    // a read taken on an enabled edge answers on the next enabled edge with
    // rd_valid_out for one cycle; rd_data_out then holds until the next answer
    // reads may follow back to back, one per enabled edge
    // the ratio snapshot loads only when its lowest byte is read; a host that
    // reads the upper bytes first gets bytes of an older ratio
    // the live low byte returned on that read equals the new snapshot
    // status bits arrive lsb first and byte 0 first; the first bit is bit 0 of byte 0
    // a status byte is written whole on its eighth bit; a block cut short keeps
    // the higher bytes of the previous block, so a read may mix two blocks
    // a read on the edge that writes a status byte still returns the old byte
    // unmapped addresses answer normally with zero data
    // reset clears the snapshot and every status byte to zero
    // ce_in low freezes every register, the status memory included

    // ****************************************************************
    // declarations
    // ****************************************************************
    rsr_ratio_t snap_r, snap_nxt;
    logic [7:0] cs_cnt_r, cs_cnt_nxt;
    rsr_byte_t cs_shift_r, cs_shift_nxt;
    logic cs_we;
    logic [`RSR_CS_IDX_W-1:0] cs_widx;
    rsr_byte_t cs_wdata;
    logic [`RSR_CS_IDX_W-1:0] cs_ridx;
    rsr_byte_t cs_rdata;
    rsr_sel_t p_sel_r, p_sel_nxt;
    rsr_byte_t p_byte_r, p_byte_nxt;
    logic p_vld_r, p_vld_nxt;
    rsr_byte_t rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [7:0] ratio_ofs;
    logic [7:0] cs_ofs;
    logic hit_ratio, hit_cs;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // offsets within each register group
    // the subtraction wraps below a group base; the range tests keep those out
    assign ratio_ofs = rd_addr_in - `RSR_RATIO_LSB;
    assign cs_ofs = rd_addr_in - `RSR_CS_LSB;
    assign hit_ratio = (rd_addr_in >= `RSR_RATIO_LSB) && (rd_addr_in <= `RSR_RATIO_MSB); // see R2
    assign hit_cs = (rd_addr_in >= `RSR_CS_LSB) && (rd_addr_in <= `RSR_CS_MSB); // see R6
    assign cs_ridx = cs_ofs[`RSR_CS_IDX_W-1:0]; // byte n at register 70 plus n, see R9

    // ****************************************************************
    // ratio snapshot
    // ****************************************************************
    // the snapshot only loads on a read of the lowest byte, never by a write
    // the bank has no write path at all, so the host cannot alter the ratio
    always_comb begin
        snap_nxt = snap_r;
        if (rd_en_in && (rd_addr_in == `RSR_RATIO_LSB)) begin
            snap_nxt = rate_ratio_in; // see R4, see R1, see R3
        end
    end

    // snapshot register
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            snap_r <= `RSR_RATIO_RST;
        end else if (ce_in) begin
            snap_r <= snap_nxt;
        end
    end

    // ****************************************************************
    // channel-status capture
    // ****************************************************************
    // bits shift in lsb first; every eighth bit writes a whole byte
    always_comb begin
        cs_cnt_nxt = cs_cnt_r;
        cs_shift_nxt = cs_shift_r;
        cs_we = 1'b0;
        cs_widx = cs_cnt_r[7:3];
        cs_wdata = {cs_bit_in, cs_shift_r[7:1]};
        if (cs_bit_valid_in) begin
            if (cs_block_start_in) begin
                // first bit of a block restarts at byte 0 bit 0
                cs_cnt_nxt = 8'h01;
                cs_shift_nxt = {cs_bit_in, 7'h00};
                cs_widx = '0;
            end else if (cs_cnt_r < `RSR_CS_BITS) begin
                cs_cnt_nxt = cs_cnt_r + 8'h01;
                cs_shift_nxt = {cs_bit_in, cs_shift_r[7:1]};
                // only a completed byte is written, a partial one never
                cs_we = (cs_cnt_r[2:0] == 3'h7); // raw bits, no decoding, see R8
            end
        end
    end

    // bit counter and partial byte
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_cnt_r <= `RSR_CS_BITS; // parked: bits without a block start are ignored
            cs_shift_r <= `RSR_BYTE_RST;
        end else if (ce_in) begin
            cs_cnt_r <= cs_cnt_nxt;
            cs_shift_r <= cs_shift_nxt;
        end
    end

    // received status bytes, read through a registered port
    rsr_cs_mem #(
        .DEPTH(CS_BYTES),
        .IDX_W(`RSR_CS_IDX_W)
    ) u_cs_mem (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .wr_en_in(cs_we), // see R7
        .wr_idx_in(cs_widx),
        .wr_data_in(cs_wdata),
        .rd_idx_in(cs_ridx),
        .rd_data_out(cs_rdata)
    );

    // ****************************************************************
    // read pipeline
    // ****************************************************************
    // stage one picks the ratio byte, stage two merges memory data
    always_comb begin
        p_vld_nxt = rd_en_in;
        p_sel_nxt = RSR_SEL_NONE;
        p_byte_nxt = `RSR_UNMAPPED;
        if (rd_en_in && hit_ratio) begin
            p_sel_nxt = RSR_SEL_RATIO;
            case (ratio_ofs[1:0])
                2'h0: begin
                    p_byte_nxt = rate_ratio_in[7:0]; // live value equals new snapshot
                end
                2'h1: begin
                    p_byte_nxt = snap_r[15:8]; // upper bytes from snapshot, see R5
                end
                2'h2: begin
                    p_byte_nxt = snap_r[23:16];
                end
                default: begin
                    p_byte_nxt = snap_r[31:24];
                end
            endcase
        end else if (rd_en_in && hit_cs) begin
            p_sel_nxt = RSR_SEL_CS;
        end
        // stage two: the memory answers one edge after the address it saw
        rd_valid_nxt = p_vld_r;
        rd_data_nxt = rd_data_r;
        if (p_vld_r) begin
            case (p_sel_r)
                RSR_SEL_RATIO: begin
                    rd_data_nxt = p_byte_r;
                end
                RSR_SEL_CS: begin
                    rd_data_nxt = cs_rdata; // see R6
                end
                default: begin
                    rd_data_nxt = `RSR_UNMAPPED;
                end
            endcase
        end
    end

    // read pipeline registers; the last two drive the output ports
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            p_sel_r <= RSR_SEL_NONE;
            p_byte_r <= `RSR_BYTE_RST;
            p_vld_r <= 1'b0;
            rd_data_r <= `RSR_BYTE_RST;
            rd_valid_r <= 1'b0;
        end else if (ce_in) begin
            p_sel_r <= p_sel_nxt;
            p_byte_r <= p_byte_nxt;
            p_vld_r <= p_vld_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // both ports come straight from the last pipeline registers
    assign rd_data_out = rd_data_r;
    assign rd_valid_out = rd_valid_r;
endmodule

// [rsr_readback_props.sv]
// assertion checker of the rate and status readback bank
`timescale 1ns/100ps
module rsr_readback_props #(
    parameter int RATIO_W = 32,
    parameter int CS_BYTES = 24
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // ratio and status capture
    input wire rsr_pkg::rsr_ratio_t rate_ratio_in,
    input wire logic cs_bit_in,
    input wire logic cs_bit_valid_in,
    input wire logic cs_block_start_in,
    // read port
    input wire logic rd_en_in,
    input wire rsr_pkg::rsr_addr_t rd_addr_in,
    input wire rsr_pkg::rsr_byte_t rd_data_out,
    input wire logic rd_valid_out
);
    import rsr_pkg::*;
    rsr_ratio_t snap_r;
    logic [8*CS_BYTES-1:0] cs_r;
    logic [7:0] cnt_r, idx, shift_r, ratio_exp, cs_exp;
    assign idx = cs_block_start_in ? 8'h00 : cnt_r;
    assign ratio_exp = 8'(snap_r >> {rd_addr_in[1:0] - 2'h2, 3'h0});
    assign cs_exp = 8'(cs_r >> {rd_addr_in - 8'h46, 3'h0});
    // reference snapshot and status block, whole bytes only
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            snap_r <= '0;
            cs_r <= '0;
            cnt_r <= 8'hC0;
            shift_r <= 8'h00;
        end else if (ce_in) begin
            if (rd_en_in && rd_addr_in == 8'h42)
                snap_r <= rate_ratio_in;
            if (cs_bit_valid_in && idx < 8'hC0) begin
                shift_r <= {cs_bit_in, shift_r[7:1]};
                cnt_r <= idx + 8'h01;
                if (idx[2:0] == 3'h7)
                    cs_r[{idx[7:3], 3'h0} +: 8] <= {cs_bit_in, shift_r[7:1]};
            end
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence req_s(lo, hi);
        ce_in && rd_en_in && rd_addr_in >= lo && rd_addr_in <= hi ##1 ce_in;
    endsequence
    valid_latency_a: assert property (req_s(8'h00, 8'hFF) |=> rd_valid_out)
        else $error("read answer missing");
    spurious_valid_a: assert property (rd_valid_out && $past(ce_in) && $past(ce_in, 2)
        |-> $past(rd_en_in, 2)) else $error("read answer without request");
    ratio_lsb_a: assert property (req_s(8'h42, 8'h42)
        |=> rd_data_out == 8'($past(rate_ratio_in, 2))) else $error("ratio low byte wrong");
    ratio_snap_a: assert property (req_s(8'h43, 8'h45)
        |=> rd_data_out == $past(ratio_exp, 2)) else $error("ratio snapshot byte wrong");
    status_byte_a: assert property (req_s(8'h46, 8'h5D)
        |=> rd_data_out == $past(cs_exp, 2)) else $error("status byte wrong");
    unmapped_zero_a: assert property (req_s(8'h00, 8'h41) or req_s(8'h5E, 8'hFF)
        |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
    data_hold_a: assert property (!rd_valid_out |-> $stable(rd_data_out))
        else $error("read data moved without answer");
    reset_clear_a: assert property ($rose(nrst_in)
        |-> rd_data_out == 8'h00 && !rd_valid_out) else $error("read port not cleared");
endmodule
bind rsr_readback rsr_readback_props #(.RATIO_W(RATIO_W), .CS_BYTES(CS_BYTES)) i_rsr_readback_props (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .rate_ratio_in(rate_ratio_in),
    .cs_bit_in(cs_bit_in), .cs_bit_valid_in(cs_bit_valid_in),
    .cs_block_start_in(cs_block_start_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));

// [rsr_host_model.sv]
// host model reading bank registers over the control port
`timescale 1ns/100ps
module rsr_host_model (
    // clock
    input wire logic sys_clk_in,
    // read request and answer
    output rsr_pkg::rsr_addr_t rd_addr_out,
    output logic rd_en_out,
    input wire rsr_pkg::rsr_byte_t rd_data_in,
    input wire logic rd_valid_in
);
    import rsr_pkg::*;
    // idle request lines
    initial begin
        rd_en_out = 1'b0;
        rd_addr_out = 8'h00;
    end
    // one read: request over one edge, answer awaited a bounded number of cycles
    task automatic read(input rsr_addr_t a, output rsr_byte_t d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge sys_clk_in);
        rd_en_out = 1'b1;
        rd_addr_out = a;
        @(negedge sys_clk_in);
        rd_en_out = 1'b0;
        rd_addr_out = ~a; // released address shows no stale value
        repeat (4) begin
            @(negedge sys_clk_in);
            if (!ok && rd_valid_in === 1'b1) begin
                ok = 1'b1;
                d = rd_data_in;
            end
        end
    endtask
endmodule

// [test_rate_and_status_readback.sv]
// self-checking bench of the rate and status readback bank
`timescale 1ns/100ps
module test_rate_and_status_readback;
    import rsr_pkg::*;
    logic sys_clk, nrst, ce, cs_bit, cs_valid, cs_start, rd_en, rd_valid;
    rsr_ratio_t ratio;
    rsr_addr_t rd_addr;
    rsr_byte_t rd_data;
    logic [191:0] blk;
    int mismatches = 0;
    int checked = 0;
    rsr_readback i_rsr_readback (.sys_clk_in(sys_clk), .nrst_in(nrst), .ce_in(ce),
        .rate_ratio_in(ratio), .cs_bit_in(cs_bit), .cs_bit_valid_in(cs_valid),
        .cs_block_start_in(cs_start), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid));
    rsr_host_model i_rsr_host_model (.sys_clk_in(sys_clk), .rd_addr_out(rd_addr),
        .rd_en_out(rd_en), .rd_data_in(rd_data), .rd_valid_in(rd_valid));
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic read_check(input rsr_addr_t a, input rsr_byte_t exp);
        rsr_byte_t d;
        bit ok;
        i_rsr_host_model.read(a, d, ok);
        checked++;
        if (!ok || d !== exp) begin
            mismatches++;
            $display("wrong value reg %h expected %h seen %h", a, exp, d);
        end
        if (!ok)
            report_and_stop();
    endtask
    task automatic send_bits(input logic [191:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge sys_clk);
            cs_valid = 1'b1;
            cs_bit = b[k];
            cs_start = (k == 0);
        end
        @(negedge sys_clk);
        cs_valid = 1'b0;
        cs_start = 1'b0;
        cs_bit = ~cs_bit; // idle bit line carries no stale value
    endtask
    task automatic test_ratio();
        ratio = 32'h89AB_CDEF;
        read_check(8'h43, 8'h00);
        read_check(8'h42, 8'hEF);
        ratio = 32'h1234_5678; // live value moves after the latch
        read_check(8'h43, 8'hCD);
        read_check(8'h44, 8'hAB);
        read_check(8'h45, 8'h89);
        read_check(8'h42, 8'h78);
    endtask
    task automatic test_status();
        for (int i = 0; i < 24; i++)
            blk[8*i +: 8] = 8'h3C + 8'(i * 37);
        blk[0] = 1'b1; // professional flag arrives first
        read_check(8'h46, 8'h00);
        send_bits(blk, 192);
        for (int i = 0; i < 24; i++)
            read_check(8'h46 + 8'(i), blk[8*i +: 8]);
        send_bits(~blk, 20); // block cut short inside byte 2
        for (int i = 0; i < 3; i++)
            read_check(8'h46 + 8'(i), i < 2 ? ~blk[8*i +: 8] : blk[8*i +: 8]);
    endtask
    task automatic test_unmapped();
        read_check(8'h41, 8'h00);
        read_check(8'h5E, 8'h00);
    endtask
    // clock enable drops for two edges right after the request is taken
    task automatic test_stall();
        fork
            read_check(8'h45, 8'h12);
            begin
                repeat (2) @(negedge sys_clk);
                ce = 1'b0;
                repeat (2) @(negedge sys_clk);
                ce = 1'b1;
            end
        join
    endtask
    // a second reset in mid-run clears the snapshot and the status bytes
    task automatic test_reset();
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        read_check(8'h43, 8'h00);
        read_check(8'h5D, 8'h00);
    endtask
    // free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // reset, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        cs_bit = 1'b0;
        cs_valid = 1'b0;
        cs_start = 1'b0;
        ratio = 32'h0000_0000;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        test_ratio();
        test_status();
        test_unmapped();
        test_stall();
        test_reset();
        report_and_stop();
    end
endmodule
